// [src/fpc_ctrl.sv]
`timescale 1ns/1ps
module fpc_ctrl (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [8:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [31:0] nv_re_in,
   input wire logic [31:0] nv_pe_in,
   output logic nv_wr_en,
   output logic nv_wr_sel_pe,
   output logic [31:0] nv_wr_data,
   output logic arr_prog,
   output logic arr_erase,
   output logic arr_mass,
   output logic [31:0] arr_addr,
   output logic [31:0] arr_data,
   input wire logic arr_done,
   output logic [15:0] block_read_en,
   output logic [15:0] block_prog_en,
   output logic debug_port_access
);
   import fpc_pkg::*;

   logic [31:0] target_addr;
   logic [31:0] write_data;
   logic [31:0] re_prot;
   logic [31:0] pe_prot;
   logic [31:0] nv_re_shadow;
   logic [1:0] raw_irq;
   logic [1:0] irq_mask;
   logic [3:0] op_bits;
   logic [7:0] usec_reload;
   logic [7:0] usec_cnt;
   logic [5:0] commit_cnt;
   logic usec_tick;
   fpc_state_e state;
   logic bus_act;
   logic wr_act;
   logic [31:0] wval;
   logic ctl_launch;
   logic [3:0] next_op;
   logic blocked;
   logic fault_set;
   logic done_set;

   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction : merge_bytes

   function automatic logic hit(input logic [8:0] a, input logic [8:0] ofs);
      return a[8:2] == ofs[8:2];
   endfunction : hit

   assign bus_act = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_act = bus_act & wb_we_i;
   assign wval = merge_bytes(32'h0000_0000, wb_dat_i, wb_sel_i);

   // Ignored unless keyed and idle
   assign ctl_launch = wr_act & hit(wb_adr_i, OFS_CTRL)
      & (wval[31:16] == LAUNCH_KEY) & (state == ST_IDLE);

   // Several bits at once is a software error; commit wins
   always_comb begin
      next_op = 4'h0;
      if (wval[CTL_COMMIT]) begin
         next_op[CTL_COMMIT] = 1'b1;
      end else if (wval[CTL_MASS]) begin
         next_op[CTL_MASS] = 1'b1;
      end else if (wval[CTL_ERASE]) begin
         next_op[CTL_ERASE] = 1'b1;
      end else if (wval[CTL_WRITE]) begin
         next_op[CTL_WRITE] = 1'b1;
      end
   end

   // Mass erase refused if any block is write-protected
   always_comb begin
      blocked = 1'b0;
      if (next_op[CTL_MASS]) begin
         blocked = ~&pe_prot[15:0];
      end else if (next_op[CTL_ERASE] | next_op[CTL_WRITE]) begin
         blocked = ~pe_prot[target_addr[BLK_LSB +: 4]];
      end
   end

   assign fault_set = ctl_launch & ~next_op[CTL_COMMIT] & blocked;
   assign done_set = (state == ST_ARRAY) & arr_done;

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_act;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wb_dat_o <= 32'h0000_0000;
      end else if (bus_act & ~wb_we_i) begin
         case (wb_adr_i[8:2])
            OFS_ADDR[8:2]: wb_dat_o <= target_addr;
            OFS_DATA[8:2]: wb_dat_o <= write_data;
            OFS_CTRL[8:2]: wb_dat_o <= {28'h0000000, op_bits};
            OFS_RIS[8:2]: wb_dat_o <= {30'h0, raw_irq};
            OFS_IM[8:2]: wb_dat_o <= {30'h0, irq_mask};
            OFS_MIS[8:2]: wb_dat_o <= {30'h0, raw_irq & irq_mask};
            OFS_RE[8:2]: wb_dat_o <= re_prot & RE_IMPL;
            OFS_PE[8:2]: wb_dat_o <= pe_prot & PE_IMPL;
            OFS_USEC[8:2]: wb_dat_o <= {24'h000000, usec_reload};
            default: wb_dat_o <= 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         target_addr <= 32'h0000_0000;
         write_data <= 32'h0000_0000;
         irq_mask <= 2'h0;
         usec_reload <= USEC_RESET;
      end else if (wr_act) begin
         if (hit(wb_adr_i, OFS_ADDR)) begin
            target_addr <= merge_bytes(target_addr, wb_dat_i, wb_sel_i);
         end
         if (hit(wb_adr_i, OFS_DATA)) begin
            write_data <= merge_bytes(write_data, wb_dat_i, wb_sel_i);
         end
         if (hit(wb_adr_i, OFS_IM)) begin
            irq_mask <= wb_sel_i[0] ? wval[1:0] : irq_mask;
         end
         if (hit(wb_adr_i, OFS_USEC)) begin
            usec_reload <= wb_sel_i[0] ? wval[7:0] : usec_reload;
         end
      end
   end

   // Plain read-enable commit keeps the stored debug field
   function automatic logic [31:0] nv_wr_data_f(input logic [31:0] a,
      input logic [31:0] re, input logic [31:0] sh);
      if (a == DBG_COMMIT_ADDR) begin
         return re & RE_IMPL;
      end
      return {sh[31:30], re[29:0]} & RE_IMPL;
   endfunction : nv_wr_data_f

   // Working copies: loaded from the store, cleared-only by software
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         re_prot <= RE_RESET;
         pe_prot <= PE_RESET;
         nv_re_shadow <= RE_RESET;
      end else if (state == ST_LOAD) begin
         re_prot <= nv_re_in & RE_IMPL;
         pe_prot <= nv_pe_in & PE_IMPL;
         nv_re_shadow <= nv_re_in & RE_IMPL;
      end else begin
         if (wr_act & hit(wb_adr_i, OFS_RE)) begin
            re_prot <= re_prot & (wval | ~{{8{wb_sel_i[3]}},
               {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
         end
         if (wr_act & hit(wb_adr_i, OFS_PE)) begin
            pe_prot <= pe_prot & (wval | ~{{8{wb_sel_i[3]}},
               {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}});
         end
         if (ctl_launch & next_op[CTL_COMMIT] & ~target_addr[0]) begin
            nv_re_shadow <= nv_wr_data_f(target_addr, re_prot,
               nv_re_shadow);
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         nv_wr_en <= 1'b0;
         nv_wr_sel_pe <= 1'b0;
         nv_wr_data <= 32'h0000_0000;
      end else begin
         nv_wr_en <= ctl_launch & next_op[CTL_COMMIT];
         if (ctl_launch & next_op[CTL_COMMIT]) begin
            nv_wr_sel_pe <= target_addr[0];
            nv_wr_data <= target_addr[0] ? (pe_prot & PE_IMPL)
               : nv_wr_data_f(target_addr, re_prot, nv_re_shadow);
         end
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         usec_cnt <= 8'h00;
         usec_tick <= 1'b0;
      end else begin
         usec_tick <= (usec_cnt == 8'h00);
         usec_cnt <= (usec_cnt == 8'h00) ? usec_reload : usec_cnt - 8'h01;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_LOAD;
         op_bits <= 4'h0;
         commit_cnt <= 6'h00;
      end else begin
         case (state)
            ST_LOAD: state <= ST_IDLE;
            ST_IDLE: begin
               if (ctl_launch & next_op[CTL_COMMIT]) begin
                  state <= ST_COMMIT;
                  op_bits <= next_op;
                  commit_cnt <= 6'h00;
               end else if (ctl_launch & (next_op != 4'h0) & ~blocked) begin
                  state <= ST_ARRAY;
                  op_bits <= next_op;
               end
            end
            ST_ARRAY: begin
               if (arr_done) begin
                  state <= ST_IDLE;
                  op_bits <= 4'h0;
               end
            end
            ST_COMMIT: begin
               if (usec_tick) begin
                  commit_cnt <= commit_cnt + 6'h01;
               end
               if (usec_tick & (commit_cnt == 6'(COMMIT_US - 1))) begin
                  state <= ST_IDLE;
                  op_bits <= 4'h0;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         arr_prog <= 1'b0;
         arr_erase <= 1'b0;
         arr_mass <= 1'b0;
         arr_addr <= 32'h0000_0000;
         arr_data <= 32'h0000_0000;
      end else if (state == ST_IDLE) begin
         arr_prog <= ctl_launch & next_op[CTL_WRITE] & ~blocked;
         arr_erase <= ctl_launch & next_op[CTL_ERASE] & ~blocked;
         arr_mass <= ctl_launch & next_op[CTL_MASS] & ~blocked;
         arr_addr <= target_addr;
         arr_data <= write_data;
      end else if (done_set) begin
         arr_prog <= 1'b0;
         arr_erase <= 1'b0;
         arr_mass <= 1'b0;
      end
   end

   // Hardware set beats a same-cycle software clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         raw_irq <= 2'h0;
      end else begin
         raw_irq <= (raw_irq & ~((wr_act & hit(wb_adr_i, OFS_MIS))
            ? wval[1:0] : 2'h0)) | {done_set, fault_set};
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         block_read_en <= 16'hffff;
         block_prog_en <= 16'hffff;
         debug_port_access <= 1'b0;
      end else begin
         block_read_en <= re_prot[15:0];
         block_prog_en <= pe_prot[15:0];
         debug_port_access <= (re_prot[31:30] == DBG_OPEN);
      end
   end

   property p_ack_drop;
      @(posedge mclk) disable iff (!rstn) wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_drop: assert property (p_ack_drop)
      else $error("ack held two cycles");

   property p_bad_key;
      @(posedge mclk) disable iff (!rstn)
      (wr_act && hit(wb_adr_i, OFS_CTRL) && wval[31:16] != LAUNCH_KEY
       && state == ST_IDLE) |=> state == ST_IDLE;
   endproperty
   a_bad_key: assert property (p_bad_key)
      else $error("unkeyed control write launched");

   property p_busy_ignore;
      @(posedge mclk) disable iff (!rstn)
      (state == ST_ARRAY && !arr_done) |=> $stable(op_bits) || op_bits == 0;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore)
      else $error("operation changed while busy");

   property p_write_bit;
      @(posedge mclk) disable iff (!rstn)
      (ctl_launch && next_op == 4'h1 && !blocked)
      |=> op_bits[CTL_WRITE] && arr_prog;
   endproperty
   a_write_bit: assert property (p_write_bit)
      else $error("write bit not set on launch");

   property p_op_clear;
      @(posedge mclk) disable iff (!rstn)
      (state == ST_ARRAY && arr_done) |=> op_bits == 4'h0;
   endproperty
   a_op_clear: assert property (p_op_clear)
      else $error("operation bit not cleared");

   property p_w0;
      @(posedge mclk) disable iff (!rstn)
      state != ST_LOAD |=> ((re_prot & ~$past(re_prot)) == 0)
         && ((pe_prot & ~$past(pe_prot)) == 0);
   endproperty
   a_w0: assert property (p_w0)
      else $error("protection bit went from 0 to 1");

   property p_commit_sel;
      @(posedge mclk) disable iff (!rstn)
      (ctl_launch && next_op[CTL_COMMIT]) |=> nv_wr_en
         && nv_wr_sel_pe == $past(target_addr[0]);
   endproperty
   a_commit_sel: assert property (p_commit_sel)
      else $error("wrong register committed");

   property p_dbg_commit;
      @(posedge mclk) disable iff (!rstn)
      (ctl_launch && next_op[CTL_COMMIT] && target_addr == DBG_COMMIT_ADDR)
      |=> nv_wr_data[31:30] == $past(re_prot[31:30]);
   endproperty
   a_dbg_commit: assert property (p_dbg_commit)
      else $error("debug field not committed");

   property p_commit_bit;
      @(posedge mclk) disable iff (!rstn)
      state == ST_COMMIT |-> op_bits[CTL_COMMIT];
   endproperty
   a_commit_bit: assert property (p_commit_bit)
      else $error("commit bit low during commit");

   property p_blocked;
      @(posedge mclk) disable iff (!rstn)
      fault_set |=> !arr_prog && !arr_erase && !arr_mass && raw_irq[RIS_FAULT];
   endproperty
   a_blocked: assert property (p_blocked)
      else $error("protected block operation started");

   property p_dbg_on;
      @(posedge mclk) disable iff (!rstn)
      state != ST_LOAD && re_prot[31:30] == DBG_OPEN |=> debug_port_access;
   endproperty
   a_dbg_on: assert property (p_dbg_on)
      else $error("debug access not enabled");

   property p_dbg_off;
      @(posedge mclk) disable iff (!rstn)
      state != ST_LOAD && re_prot[31:30] != DBG_OPEN |=> !debug_port_access;
   endproperty
   a_dbg_off: assert property (p_dbg_off)
      else $error("debug access not disabled");
endmodule : fpc_ctrl

// [src/fpc_pkg.sv]
package fpc_pkg;
   localparam logic [8:0] OFS_ADDR = 9'h000;
   localparam logic [8:0] OFS_DATA = 9'h004;
   localparam logic [8:0] OFS_CTRL = 9'h008;
   localparam logic [8:0] OFS_RIS = 9'h00c;
   localparam logic [8:0] OFS_IM = 9'h010;
   localparam logic [8:0] OFS_MIS = 9'h014;
   localparam logic [8:0] OFS_RE = 9'h130;
   localparam logic [8:0] OFS_PE = 9'h134;
   localparam logic [8:0] OFS_USEC = 9'h140;
   localparam logic [15:0] LAUNCH_KEY = 16'ha442;
   localparam int CTL_WRITE = 0;
   localparam int CTL_ERASE = 1;
   localparam int CTL_MASS = 2;
   localparam int CTL_COMMIT = 3;
   localparam logic [31:0] DBG_COMMIT_ADDR = 32'h0000_0900;
   localparam logic [31:0] RE_RESET = 32'h8000_ffff;
   localparam logic [31:0] PE_RESET = 32'h0000_ffff;
   localparam logic [31:0] RE_IMPL = 32'hc000_ffff;
   localparam logic [31:0] PE_IMPL = 32'h0000_ffff;
   localparam logic [1:0] DBG_OPEN = 2'h2;
   localparam logic [7:0] USEC_RESET = 8'h31;
   localparam int COMMIT_US = 50;
   localparam int BLK_LSB = 11;
   localparam int RIS_FAULT = 0;
   localparam int RIS_DONE = 1;
   typedef enum logic [1:0] {
      ST_LOAD = 2'b00,
      ST_IDLE = 2'b01,
      ST_ARRAY = 2'b10,
      ST_COMMIT = 2'b11
   } fpc_state_e;
endpackage : fpc_pkg

// [sim/fpc_ctrl_test.sv]
`timescale 1ns/1ps
module fpc_ctrl_test;
   import fpc_pkg::*;
   localparam logic [31:0] ALL = 32'hffff_ffff;
   localparam logic [31:0] KEY = 32'ha442_0000;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, done = 1'b0;
   logic [8:0] adr = 9'h0;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, v, a, d, nvd;
   logic [31:0] nv_re = 32'h8000_ffff, nv_pe = 32'h0000_ffff;
   logic [31:0] dat_o, nv_data, arr_addr, arr_data;
   logic ack, nv_en, nv_sel, pr, er, ms, dbg, nvs;
   logic [15:0] bre, bpe;
   logic [63:0] sbq[$];
   logic [63:0] e;
   int error_cnt = 0, n_tests = 0, cnt = 0, nv_cnt = 0, i, k;

   fpc_ctrl uut (.mclk(mclk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .nv_re_in(nv_re), .nv_pe_in(nv_pe),
      .nv_wr_en(nv_en), .nv_wr_sel_pe(nv_sel), .nv_wr_data(nv_data),
      .arr_prog(pr), .arr_erase(er), .arr_mass(ms), .arr_addr(arr_addr),
      .arr_data(arr_data), .arr_done(done), .block_read_en(bre),
      .block_prog_en(bpe), .debug_port_access(dbg));

   initial begin
      forever #5 mclk = ~mclk;
   end

   task final_report;
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : final_report

   task check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // Entered and left just after a rising edge
   task bus(input logic w, input logic [8:0] ad, input logic [31:0] dt);
      int j;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      wdat <= dt;
      sel <= 4'hf;
      for (j = 0; j < 50; j++) begin
         @(posedge mclk);
         if (ack === 1'b1) break;
      end
      if (j == 50) begin
         error_cnt++;
         final_report();
      end
      v = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge mclk);
   endtask : bus

   task wr(input logic [8:0] ad, input logic [31:0] dt);
      bus(1'b1, ad, dt);
   endtask : wr

   task rd(input logic [8:0] ad, input logic [31:0] x, input logic [31:0] m);
      sbq.push_back({x, m});
      bus(1'b0, ad, 32'h0);
   endtask : rd

   // Polls with no expectation; only the bit matters
   task poll(input int b);
      int n;
      for (n = 0; n < 4000; n++) begin
         rd(OFS_CTRL, 32'h0, 32'h0);
         if (v[b] === 1'b0) break;
      end
      if (n == 4000) begin
         error_cnt++;
         final_report();
      end
   endtask : poll

   task do_reset;
      rstn <= 1'b0;
      repeat (12) @(posedge mclk);
      rstn <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask : do_reset

   // Read data compared against the oldest note at the ack edge
   always @(posedge mclk) begin
      if (ack === 1'b1 && we === 1'b0) begin
         e = sbq.pop_front();
         if (e[31:0] != 32'h0) check(dat_o & e[31:0], e[63:32]);
      end
   end

   // Nonvolatile store and array timing, as the far side would behave
   always @(posedge mclk) begin
      if (nv_en === 1'b1) begin
         nv_cnt <= nv_cnt + 1;
         nvd <= nv_data;
         nvs <= nv_sel;
         if (nv_sel) nv_pe <= nv_data;
         else nv_re <= nv_data;
      end
      if ((pr | er | ms) === 1'b1 && done === 1'b0) begin
         if (cnt == 0) done <= 1'b1;
         else cnt <= cnt - 1;
      end else begin
         done <= 1'b0;
         cnt <= 8 + $urandom % 8;
      end
   end

   logic [8:0] ofs[9] = '{OFS_ADDR, OFS_DATA, OFS_CTRL, OFS_RIS, OFS_IM,
      OFS_MIS, OFS_RE, OFS_PE, OFS_USEC};
   logic [31:0] rv[9] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
      32'h8000_ffff, 32'h0000_ffff, 32'h31};

   initial begin
      void'($urandom(32'h1bc5b76d));
      do_reset();
      for (i = 0; i < 9; i++) rd(ofs[i], rv[i], ALL);
      rd(9'h100, 32'h0, ALL);
      check({16'h0, bre}, 32'hffff);
      check({31'h0, dbg}, 32'h1);
      wr(OFS_USEC, 32'h63);
      rd(OFS_USEC, 32'h63, 32'hff);
      wr(OFS_IM, 32'h3);
      rd(OFS_IM, 32'h3, ALL);
      for (i = 0; i < 3; i++) begin
         d = $urandom;
         a = ($urandom % 16) << 11;
         wr(OFS_DATA, d);
         wr(OFS_ADDR, a);
         wr(OFS_CTRL, KEY | (32'h1 << i));
         wr(OFS_CTRL, KEY | (32'h1 << ((i + 1) % 3)));
         rd(OFS_CTRL, 32'h1 << i, ALL);
         check({29'h0, ms, er, pr}, 32'h1 << i);
         if (i < 2) check(arr_addr, a);
         if (i == 0) check(arr_data, d);
         poll(i);
         rd(OFS_RIS, 32'h2, 32'h2);
      end
      wr(OFS_CTRL, 32'h5a42_0001);
      rd(OFS_CTRL, 32'h0, ALL);
      check({31'h0, pr}, 32'h0);
      wr(OFS_PE, 32'h0000_fffe);
      wr(OFS_PE, 32'h0000_ffff);
      rd(OFS_PE, 32'h0000_fffe, ALL);
      check({16'h0, bpe}, 32'hfffe);
      wr(OFS_ADDR, 32'h0000_0404);
      wr(OFS_CTRL, KEY | 32'h1);
      rd(OFS_CTRL, 32'h0, ALL);
      rd(OFS_RIS, 32'h1, 32'h1);
      rd(OFS_MIS, 32'h3, 32'h3);
      wr(OFS_MIS, 32'h3);
      rd(OFS_MIS, 32'h0, 32'h3);
      k = nv_cnt;
      wr(OFS_ADDR, 32'h1);
      wr(OFS_CTRL, KEY | 32'h8);
      rd(OFS_CTRL, 32'h8, ALL);
      check(32'(nv_cnt - k), 32'h1);
      check({31'h0, nvs}, 32'h1);
      check(nvd & 32'hffff, 32'hfffe);
      poll(3);
      wr(OFS_RE, 32'h0000_fff7);
      check({31'h0, dbg}, 32'h0);
      check({16'h0, bre}, 32'hfff7);
      rd(OFS_RE, 32'h0000_fff7, ALL);
      wr(OFS_ADDR, 32'h900);
      wr(OFS_CTRL, KEY | 32'h8);
      poll(3);
      check({31'h0, nvs}, 32'h0);
      check(nvd, 32'h0000_fff7);
      // Uncommitted clear must not survive power-on
      wr(OFS_PE, 32'h0000_ffde);
      do_reset();
      rd(OFS_PE, 32'h0000_fffe, ALL);
      rd(OFS_RE, 32'h0000_fff7, ALL);
      check({31'h0, dbg}, 32'h0);
      final_report();
   end
endmodule : fpc_ctrl_test
